// File: hdl/ipcfg_pkg.sv
// Package for the interrupt priority configuration store: map, fields, resets, carriers
package ipcfg_pkg;
  // Byte offsets of the three priority registers on the register bus
  localparam logic [3:0] IPCFG_GROUP_ONE_OFS = 4'h0;
  localparam logic [3:0] IPCFG_GROUP_TWO_OFS = 4'h4;
  localparam logic [3:0] IPCFG_GROUP_THREE_OFS = 4'h8;
  // Field low-bit positions inside a 16-bit priority register
  localparam int IPCFG_FLD3_LSB = 12;
  localparam int IPCFG_FLD2_LSB = 8;
  localparam int IPCFG_FLD1_LSB = 4;
  localparam int IPCFG_FLD0_LSB = 0;
  // Priority encodings
  localparam logic [2:0] IPCFG_PRIO_RESET = 3'h4;
  localparam logic [2:0] IPCFG_PRIO_OFF = 3'h0;
  // AXI responses
  localparam logic [1:0] IPCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPCFG_RESP_SLVERR = 2'h2;

  typedef logic [2:0] ipcfg_prio_t;

  // Priority levels handed to the arbitration logic
  typedef struct packed {
    ipcfg_prio_t compare1_priority;
    ipcfg_prio_t capture1_priority;
    ipcfg_prio_t ext_irq0_priority;
    ipcfg_prio_t timer2_priority;
    ipcfg_prio_t compare2_priority;
    ipcfg_prio_t capture2_priority;
    ipcfg_prio_t dma_ch0_priority;
    ipcfg_prio_t serial1_rx_priority;
    ipcfg_prio_t sync_serial1_event_priority;
    ipcfg_prio_t sync_serial1_error_priority;
    ipcfg_prio_t timer3_priority;
  } ipcfg_prios_s;

  // Raw requests from the eleven sources (flag and enable already combined)
  typedef struct packed {
    logic compare1;
    logic capture1;
    logic ext_irq0;
    logic timer2;
    logic compare2;
    logic capture2;
    logic dma_ch0;
    logic serial1_rx;
    logic sync_serial1_event;
    logic sync_serial1_error;
    logic timer3;
  } ipcfg_reqs_s;

  // Whole state of the block
  typedef struct packed {
    ipcfg_prios_s prio;
    ipcfg_reqs_s req_out;
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipcfg_state_s;
endpackage : ipcfg_pkg

// File: hdl/ipcfg_top.sv
// Interrupt priority configuration store with AXI4-Lite register access
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Every source owns a 3-bit priority; code 111 means level 7, the highest.
// - Code 001 is level 1, the lowest active; codes between map to 2 to 6.
// - Code 000 disables the source; it never forwards a request.
// - Separator bits 15, 11, 7 and 3 always read back zero.
// - Reset puts every field at 100, level 4; all field bits read and write.
// - Group one: compare1 at 10-8, capture1 at 6-4, external 0 at 2-0.
// - Group two: timer2 14-12, compare2 10-8, capture2 6-4, DMA ch0 2-0.
// - Group three: serial1 rx 14-12, sync serial event 10-8, error 6-4, timer3 2-0.
module ipcfg_top
  import ipcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ipcfg_reqs_s src_req,
  output ipcfg_prios_s prio_out,
  output ipcfg_reqs_s req_out
);

  ipcfg_state_s st_ff;
  ipcfg_state_s nxt_st;

  // Place four fields into a register image, separators left at zero
  function automatic logic [15:0] ipcfg_pack(input ipcfg_prio_t f3, input ipcfg_prio_t f2,
                                             input ipcfg_prio_t f1, input ipcfg_prio_t f0);
    logic [15:0] img;
    img = 16'h0000;
    img[IPCFG_FLD3_LSB +: 3] = f3;
    img[IPCFG_FLD2_LSB +: 3] = f2;
    img[IPCFG_FLD1_LSB +: 3] = f1;
    img[IPCFG_FLD0_LSB +: 3] = f0;
    return img;
  endfunction : ipcfg_pack

  // Merge a write into a 3-bit field honouring the byte strobes
  function automatic ipcfg_prio_t ipcfg_merge(input ipcfg_prio_t cur, input logic [15:0] wd,
                                              input logic [1:0] strb, input int lsb);
    ipcfg_prio_t res;
    res = cur;
    if (strb[lsb / 8]) begin
      res = wd[lsb +: 3];
    end
    return res;
  endfunction : ipcfg_merge

  // Level 0 blocks a source, any other level lets it through
  function automatic logic ipcfg_gate(input logic req, input ipcfg_prio_t lvl);
    return req && (lvl != IPCFG_PRIO_OFF);
  endfunction : ipcfg_gate

  // Read decode of the register map
  function automatic logic [31:0] ipcfg_read(input ipcfg_prios_s p, input logic [3:0] a);
    logic [31:0] rd;
    rd = 32'h0000_0000;
    unique case (a)
      IPCFG_GROUP_ONE_OFS: begin
        rd[15:0] = ipcfg_pack(IPCFG_PRIO_OFF, p.compare1_priority,
                              p.capture1_priority, p.ext_irq0_priority);
      end
      IPCFG_GROUP_TWO_OFS: begin
        rd[15:0] = ipcfg_pack(p.timer2_priority, p.compare2_priority,
                              p.capture2_priority, p.dma_ch0_priority);
      end
      IPCFG_GROUP_THREE_OFS: begin
        rd[15:0] = ipcfg_pack(p.serial1_rx_priority,
                              p.sync_serial1_event_priority,
                              p.sync_serial1_error_priority, p.timer3_priority);
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
    return rd;
  endfunction : ipcfg_read

  // Only the three word addresses exist
  function automatic logic ipcfg_mapped(input logic [31:0] a);
    return (a[31:4] == 28'h000_0000) && (a[3:0] == IPCFG_GROUP_ONE_OFS ||
           a[3:0] == IPCFG_GROUP_TWO_OFS || a[3:0] == IPCFG_GROUP_THREE_OFS);
  endfunction : ipcfg_mapped

  // Next-state logic: bus slave, field updates and request gating
  always_comb begin
    logic [15:0] wd;
    logic [1:0] ws;
    logic do_write;
    wd = 16'h0000;
    ws = 2'b00;
    do_write = 1'b0;
    nxt_st = st_ff;

    // Capture address and data independently, in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awready = 1'b0;
      nxt_st.aw_addr = ipcfg_mapped(s_axi_awaddr) ? s_axi_awaddr[3:0] : 4'hf;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wready = 1'b0;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end

    // Commit once both halves are held and no response is pending
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      do_write = 1'b1;
      wd = st_ff.w_data[15:0];
      ws = st_ff.w_strb[1:0];
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (st_ff.aw_addr == 4'hf) ? IPCFG_RESP_SLVERR : IPCFG_RESP_OKAY;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    // Field writes; separator bits of the write data are dropped
    if (do_write) begin
      unique case (st_ff.aw_addr)
        IPCFG_GROUP_ONE_OFS: begin
          nxt_st.prio.compare1_priority =
            ipcfg_merge(st_ff.prio.compare1_priority, wd, ws, IPCFG_FLD2_LSB);
          nxt_st.prio.capture1_priority =
            ipcfg_merge(st_ff.prio.capture1_priority, wd, ws, IPCFG_FLD1_LSB);
          nxt_st.prio.ext_irq0_priority =
            ipcfg_merge(st_ff.prio.ext_irq0_priority, wd, ws, IPCFG_FLD0_LSB);
        end
        IPCFG_GROUP_TWO_OFS: begin
          nxt_st.prio.timer2_priority =
            ipcfg_merge(st_ff.prio.timer2_priority, wd, ws, IPCFG_FLD3_LSB);
          nxt_st.prio.compare2_priority =
            ipcfg_merge(st_ff.prio.compare2_priority, wd, ws, IPCFG_FLD2_LSB);
          nxt_st.prio.capture2_priority =
            ipcfg_merge(st_ff.prio.capture2_priority, wd, ws, IPCFG_FLD1_LSB);
          nxt_st.prio.dma_ch0_priority =
            ipcfg_merge(st_ff.prio.dma_ch0_priority, wd, ws, IPCFG_FLD0_LSB);
        end
        IPCFG_GROUP_THREE_OFS: begin
          nxt_st.prio.serial1_rx_priority =
            ipcfg_merge(st_ff.prio.serial1_rx_priority, wd, ws, IPCFG_FLD3_LSB);
          nxt_st.prio.sync_serial1_event_priority =
            ipcfg_merge(st_ff.prio.sync_serial1_event_priority, wd, ws, IPCFG_FLD2_LSB);
          nxt_st.prio.sync_serial1_error_priority =
            ipcfg_merge(st_ff.prio.sync_serial1_error_priority, wd, ws, IPCFG_FLD1_LSB);
          nxt_st.prio.timer3_priority =
            ipcfg_merge(st_ff.prio.timer3_priority, wd, ws, IPCFG_FLD0_LSB);
        end
        default: begin
          nxt_st.prio = st_ff.prio;
        end
      endcase
    end

    // Read channel: one cycle from address to data
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = ipcfg_read(st_ff.prio, ipcfg_mapped(s_axi_araddr) ?
                                s_axi_araddr[3:0] : 4'hf);
      nxt_st.rresp = ipcfg_mapped(s_axi_araddr) ? IPCFG_RESP_OKAY : IPCFG_RESP_SLVERR;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // Requests gated by level; levels 1..7 pass to arbitration through the state register, one cycle later
    nxt_st.req_out.compare1 = ipcfg_gate(src_req.compare1, st_ff.prio.compare1_priority);
    nxt_st.req_out.capture1 = ipcfg_gate(src_req.capture1, st_ff.prio.capture1_priority);
    nxt_st.req_out.ext_irq0 = ipcfg_gate(src_req.ext_irq0, st_ff.prio.ext_irq0_priority);
    nxt_st.req_out.timer2 = ipcfg_gate(src_req.timer2, st_ff.prio.timer2_priority);
    nxt_st.req_out.compare2 = ipcfg_gate(src_req.compare2, st_ff.prio.compare2_priority);
    nxt_st.req_out.capture2 = ipcfg_gate(src_req.capture2, st_ff.prio.capture2_priority);
    nxt_st.req_out.dma_ch0 = ipcfg_gate(src_req.dma_ch0, st_ff.prio.dma_ch0_priority);
    nxt_st.req_out.serial1_rx =
      ipcfg_gate(src_req.serial1_rx, st_ff.prio.serial1_rx_priority);
    nxt_st.req_out.sync_serial1_event =
      ipcfg_gate(src_req.sync_serial1_event, st_ff.prio.sync_serial1_event_priority);
    nxt_st.req_out.sync_serial1_error =
      ipcfg_gate(src_req.sync_serial1_error, st_ff.prio.sync_serial1_error_priority);
    nxt_st.req_out.timer3 = ipcfg_gate(src_req.timer3, st_ff.prio.timer3_priority);
  end

  // State register; every field starts at level 4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.prio <= {11{IPCFG_PRIO_RESET}};
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register; level code is passed as is
  assign prio_out = st_ff.prio;
  assign req_out = st_ff.req_out;
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

endmodule : ipcfg_top
`default_nettype wire

// File: test/ipcfg_src_model.sv
// Source model: random request levels from the eleven interrupt sources
`timescale 1ns/1ps
`default_nettype none
module ipcfg_src_model
  import ipcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic en,
  output var ipcfg_reqs_s src_req
);
  int seed = 21435;
  // New pattern each cycle; frozen so a check can see settled levels
  initial src_req = '0;
  always @(posedge aclk) begin
    if (en) src_req <= ipcfg_reqs_s'(11'($random(seed)));
  end
endmodule : ipcfg_src_model
`default_nettype wire

// File: test/ipcfg_sva.sv
// Checker for the interrupt priority store, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ipcfg_sva
  import ipcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ipcfg_reqs_s src_req,
  input wire ipcfg_prios_s prio_out,
  input wire ipcfg_reqs_s req_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [10:0] live_req;
  // A zero level masks its source whatever the request does
  always_comb begin
    for (int i = 0; i < 11; i++) live_req[i] = src_req[i] && (prio_out[3*i +: 3] != 3'h0);
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_req_gate: assert property ($past(aresetn) |-> req_out == $past(live_req))
    else $error("source gating wrong");
  a_wr_resp: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_sep_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffff_8888) == '0)
    else $error("separator bit set");
  a_reset_level: assert property ($rose(aresetn) |-> prio_out == {11{3'h4}})
    else $error("reset level wrong");
  a_prio_commit: assert property ($past(aresetn) && !$stable(prio_out) |-> $rose(s_axi_bvalid))
    else $error("level changed without write");
  a_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
endmodule : ipcfg_sva
bind ipcfg_top ipcfg_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .src_req, .prio_out, .req_out);
`default_nettype wire

// File: test/tb_ipcfg.sv
// Testbench for the interrupt priority store against a register model
`timescale 1ns/1ps
`default_nettype none
module tb_ipcfg
  import ipcfg_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, src_en;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ipcfg_reqs_s src_req, req_out;
  ipcfg_prios_s prio_out;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 21435;
  logic [15:0] regs_m [3];
  ipcfg_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_req, .prio_out, .req_out);
  ipcfg_src_model i_src (.aclk, .en(src_en), .src_req);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Model view of the levels, in the carrier's field order
  function automatic ipcfg_prios_s exp_prio();
    return {regs_m[0][10:8], regs_m[0][6:4], regs_m[0][2:0], regs_m[1][14:12],
      regs_m[1][10:8], regs_m[1][6:4], regs_m[1][2:0], regs_m[2][14:12], regs_m[2][10:8],
      regs_m[2][6:4], regs_m[2][2:0]};
  endfunction : exp_prio
  task automatic wr(input logic [31:0] a, input logic [31:0] dt, input logic [3:0] s);
    logic [15:0] m;
    logic aw_go;
    logic w_go;
    // Idle edge first, so back-to-back calls never drive a signal twice in one step
    @(posedge aclk);
    aw_go = 1'b1;
    w_go = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Local flags track each channel; the driven valids only update after the step
    while (aw_go || w_go) begin
      @(posedge aclk);
      if (aw_go && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_go = 1'b0;
      end
      if (w_go && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_go = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", 33'(a < 12 ? IPCFG_RESP_OKAY : IPCFG_RESP_SLVERR), 33'(s_axi_bresp));
    // Group one has no field at 14:12, so those bits never store
    m = {s[1] ? 8'hff : 8'h00, s[0] ? 8'hff : 8'h00} & (a == 0 ? 16'h0777 : 16'h7777);
    if (a < 12) regs_m[a[3:2]] = (regs_m[a[3:2]] & ~m) | (dt[15:0] & m);
    chk("prio_out", 33'(exp_prio()), 33'(prio_out));
  endtask : wr
  task automatic rdr(input logic [31:0] a);
    // Idle edge first, so rready is not driven twice in one step
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", 33'(a < 12 ? {16'h0000, regs_m[a[3:2]]} : 32'h0000_0000), 33'(s_axi_rdata));
    chk("rresp", 33'(a < 12 ? IPCFG_RESP_OKAY : IPCFG_RESP_SLVERR), 33'(s_axi_rresp));
  endtask : rdr
  // Freeze the sources so the registered gate has settled before comparing
  task automatic gate();
    ipcfg_prios_s p;
    ipcfg_reqs_s ex;
    src_en <= 1'b0;
    repeat (3) @(posedge aclk);
    p = exp_prio();
    ex = src_req;
    for (int i = 0; i < 11; i++) if (p[3*i +: 3] == 3'h0) ex[i] = 1'b0;
    chk("req_out", 33'(ex), 33'(req_out));
    src_en <= 1'b1;
  endtask : gate
  // Hold reset for n edges, then every level and every mapped field must be back at 4
  task automatic rst_chk(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    src_en <= 1'b1;
    regs_m = '{16'h0444, 16'h4444, 16'h4444};
    @(posedge aclk);
    chk("prio_rst", 33'(exp_prio()), 33'(prio_out));
    for (int a = 0; a < 16; a += 4) rdr(32'(a));
    $display("reset test done");
  endtask : rst_chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    src_en = 1'b0;
    rst_chk(20);
    // Every code in every field, separators and upper bits written as ones
    for (int c = 0; c < 8; c++) begin
      for (int a = 0; a < 12; a += 4) wr(32'(a), 32'hffff_8888 | 32'(c * 'h1111), 4'hf);
      for (int a = 0; a < 12; a += 4) rdr(32'(a));
      gate();
    end
    $display("code test done");
    // Random words, strobes and addresses, unmapped ones included
    for (int n = 0; n < 40; n++) begin
      wr($random(seed) & 32'h1c, $random(seed), 4'($random(seed)));
      rdr($random(seed) & 32'h1c);
      gate();
    end
    $display("random test done");
    // Reset in mid-run, after random levels, must restore level 4 everywhere
    rst_chk(2);
    summarize();
  end
  // A hung handshake ends the run as a failure
  initial begin
    #100us;
    miscompares++;
    summarize();
  end
endmodule : tb_ipcfg
`default_nettype wire
